// file: hw/ump_cfg.svh
`ifndef UMP_CFG_SVH
`define UMP_CFG_SVH

// ************************************************
// Register field positions
// ************************************************
`define UMP_MCR_DTR_BIT     0
`define UMP_MCR_IRQEN_BIT   3
`define UMP_EFR_AUTOCTS_BIT 7
`define UMP_IER_RXAVL_BIT   0
`define UMP_IER_TXEMP_BIT   1
`define UMP_IER_LINE_BIT    2
`define UMP_IER_MODEM_BIT   3

// ************************************************
// Reset values
// ************************************************
`define UMP_MCR_RST         8'h00
`define UMP_EFR_RST         8'h00
`define UMP_IER_RST         8'h00

// ************************************************
// Sizes
// ************************************************
`define UMP_NCH             4
`define UMP_BUS_W           8
`define UMP_SYNC_STAGES     3

`endif

// file: hw/ump_pkg.sv
package ump_pkg;

  // ************************************************
  // Modem status byte, bit 7 first
  // ************************************************
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
    logic ddcd;
    logic teri;
    logic ddsr;
    logic dcts;
  } ump_msr_t;

  // ************************************************
  // Interrupt conditions of one channel
  // ************************************************
  typedef struct packed {
    logic rx_err;
    logic tx_empty;
    logic rx_avail;
  } ump_irq_src_t;

endpackage : ump_pkg

// file: hw/ump_modem_irq.sv
`timescale 1ns/10ps
`include "ump_cfg.svh"
// Function
// - Low clear-to-send means ready, in status bit4
// - Clear-to-send gates traffic only with auto-flow
// - Eight-bit three-state host bus, bit0 first
// - Data-set-ready low is ready, status only
// - Control bit0 one drives terminal-ready low
// - Terminal-ready high after bit0 zero, reset
// - Separate-select mode: one interrupt per channel
// - Interrupt needs control bit3 or select pin high, enable, condition
// - Conditions: errors, data, tx empty, modem
// - Select pin high drives interrupts continuously
// - Select pin low lets control bit3 gate
// - Select pin ignored in shared-select mode
module ump_modem_irq
  import ump_pkg::*;
#(
  parameter int NCH = `UMP_NCH
)(
  input  wire logic                   CLK,
  input  wire logic                   RST_B,
  input  wire logic                   MODE_SEP_CS,
  input  wire logic                   IRQ_OUTPUT_SELECT,
  input  wire logic [NCH-1:0]         CTS_B,
  input  wire logic [NCH-1:0]         DSR_B,
  input  wire logic [NCH-1:0]         MCR_WR,
  input  wire logic [NCH-1:0]         EFR_WR,
  input  wire logic [NCH-1:0]         IER_WR,
  input  wire logic [NCH-1:0]         MSR_RD,
  input  wire logic [7:0]             HOST_DATA_BUS_I,
  input  wire ump_irq_src_t [NCH-1:0] IRQ_SRC,
  input  wire logic [NCH-1:0]         TX_START_REQ,
  output logic [NCH-1:0]              TX_START_OK,
  output logic [NCH-1:0]              DTR_B,
  output logic [NCH-1:0]              CHANNEL_IRQ_OUT,
  output logic [NCH-1:0]              CHANNEL_IRQ_OE,
  output logic [7:0]                  HOST_DATA_BUS_O,
  output logic                        HOST_DATA_BUS_OE
);

  localparam int PW = 2*NCH+1;
  // Select pin idles low on its pull-down; modem pins idle high
  localparam logic [PW-1:0] SYNC_RST = {1'b0, {(2*NCH){1'b1}}};

  initial
  begin
    if (NCH < 1 || NCH > 8)
      $error("NCH out of range");
  end

  // ************************************************
  // Pin synchronisers
  // ************************************************
  // Second and third stage must agree before the filtered value moves
  logic [PW-1:0] s1_q, s2_q, s3_q, filt_q;
  logic [PW-1:0] filt_d;

  always_comb
  begin
    filt_d = filt_q;
    for (int b = 0; b < PW; b++)
    begin
      if (s2_q[b] == s3_q[b])
        filt_d[b] = s3_q[b];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      s1_q   <= SYNC_RST;
      s2_q   <= SYNC_RST;
      s3_q   <= SYNC_RST;
      filt_q <= SYNC_RST;
    end
    else
    begin
      s1_q   <= {IRQ_OUTPUT_SELECT, DSR_B, CTS_B};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  logic [NCH-1:0] cts_act, dsr_act;
  logic           irq_sel_f;
  assign cts_act   = ~filt_q[NCH-1:0];
  assign dsr_act   = ~filt_q[2*NCH-1:NCH];
  assign irq_sel_f = filt_q[PW-1];

  // ************************************************
  // Channel registers and modem status
  // ************************************************
  logic [NCH-1:0][7:0] mcr_q, mcr_d, efr_q, efr_d, ier_q, ier_d;
  logic [NCH-1:0]      dcts_q, dcts_d, ddsr_q, ddsr_d;
  logic [NCH-1:0]      cts_prev_q, dsr_prev_q;

  function automatic ump_msr_t msr_of(input logic cts, input logic dsr,
                                      input logic dc, input logic dd);
    ump_msr_t m;
    m      = '0;
    m.cts  = cts;
    m.dsr  = dsr;
    m.dcts = dc;
    m.ddsr = dd;
    return m;
  endfunction : msr_of

  always_comb
  begin
    mcr_d  = mcr_q;
    efr_d  = efr_q;
    ier_d  = ier_q;
    dcts_d = dcts_q;
    ddsr_d = ddsr_q;
    for (int c = 0; c < NCH; c++)
    begin
      if (MCR_WR[c])
        mcr_d[c] = HOST_DATA_BUS_I;
      if (EFR_WR[c])
        efr_d[c] = HOST_DATA_BUS_I;
      if (IER_WR[c])
        ier_d[c] = HOST_DATA_BUS_I;
      // Read clears deltas, but a change in the same cycle wins
      if (MSR_RD[c])
      begin
        dcts_d[c] = 1'b0;
        ddsr_d[c] = 1'b0;
      end
      if (cts_act[c] != cts_prev_q[c])
        dcts_d[c] = 1'b1;
      if (dsr_act[c] != dsr_prev_q[c])
        ddsr_d[c] = 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      mcr_q      <= {NCH{`UMP_MCR_RST}};
      efr_q      <= {NCH{`UMP_EFR_RST}};
      ier_q      <= {NCH{`UMP_IER_RST}};
      dcts_q     <= '0;
      ddsr_q     <= '0;
      cts_prev_q <= '0;
      dsr_prev_q <= '0;
    end
    else
    begin
      mcr_q      <= mcr_d;
      efr_q      <= efr_d;
      ier_q      <= ier_d;
      dcts_q     <= dcts_d;
      ddsr_q     <= ddsr_d;
      cts_prev_q <= cts_act;
      dsr_prev_q <= dsr_act;
    end
  end

  // ************************************************
  // Outputs: terminal ready, flow control, interrupts, host bus
  // ************************************************
  logic [NCH-1:0] dtr_b_q, dtr_b_d, txok_q, txok_d;
  logic [NCH-1:0] irq_q, irq_d, irq_oe_q, irq_oe_d;
  logic [7:0]     bus_o_q, bus_o_d;
  logic           bus_oe_q, bus_oe_d;

  always_comb
  begin
    bus_o_d  = '0;
    bus_oe_d = 1'b0;
    for (int c = 0; c < NCH; c++)
    begin
      dtr_b_d[c] = ~mcr_d[c][`UMP_MCR_DTR_BIT];
      // Data-set-ready deliberately absent here
      txok_d[c]  = TX_START_REQ[c] &
                   (~efr_q[c][`UMP_EFR_AUTOCTS_BIT] | cts_act[c]);
      irq_d[c]   = 1'b0;
      irq_oe_d[c] = 1'b0;
      if (MODE_SEP_CS)
      begin
        irq_oe_d[c] = irq_sel_f | mcr_q[c][`UMP_MCR_IRQEN_BIT];
        irq_d[c]    = irq_oe_d[c] &
                      ((ier_q[c][`UMP_IER_RXAVL_BIT] & IRQ_SRC[c].rx_avail) |
                       (ier_q[c][`UMP_IER_TXEMP_BIT] & IRQ_SRC[c].tx_empty) |
                       (ier_q[c][`UMP_IER_LINE_BIT]  & IRQ_SRC[c].rx_err)   |
                       (ier_q[c][`UMP_IER_MODEM_BIT] &
                        (dcts_q[c] | ddsr_q[c])));
      end
    end
    // Lowest selected channel wins a read; bit 0 on the bus is bit 0
    for (int c = NCH-1; c >= 0; c--)
    begin
      if (MSR_RD[c])
      begin
        bus_o_d  = msr_of(cts_act[c], dsr_act[c], dcts_q[c], ddsr_q[c]);
        bus_oe_d = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      dtr_b_q  <= '1;
      txok_q   <= '0;
      irq_q    <= '0;
      irq_oe_q <= '0;
      bus_o_q  <= '0;
      bus_oe_q <= 1'b0;
    end
    else
    begin
      dtr_b_q  <= dtr_b_d;
      txok_q   <= txok_d;
      irq_q    <= irq_d;
      irq_oe_q <= irq_oe_d;
      bus_o_q  <= bus_o_d;
      bus_oe_q <= bus_oe_d;
    end
  end

  assign DTR_B            = dtr_b_q;
  assign TX_START_OK      = txok_q;
  assign CHANNEL_IRQ_OUT  = irq_q;
  assign CHANNEL_IRQ_OE   = irq_oe_q;
  assign HOST_DATA_BUS_O  = bus_o_q;
  assign HOST_DATA_BUS_OE = bus_oe_q;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  for (genvar g = 0; g < NCH; g++)
  begin : g_chk
    a_dtr_follows_mcr: assert property (
      MCR_WR[g] |=> DTR_B[g] == !$past(HOST_DATA_BUS_I[0]))
      else $error("terminal ready does not follow control bit0");
    a_dtr_after_reset: assert property (
      $rose(RST_B) |-> DTR_B[g])
      else $error("terminal ready low after reset");
    a_cts_status_bit: assert property (
      $stable(CTS_B[g]) [*5] ##1 MSR_RD[g] |=> HOST_DATA_BUS_O[4] == !$past(CTS_B[g], 2))
      else $error("status bit4 does not reflect clear-to-send");
    a_autocts_holds: assert property (
      efr_q[g][7] && !cts_act[g] && TX_START_REQ[g] |=> !TX_START_OK[g])
      else $error("character started while clear-to-send high");
    a_cts_status_only: assert property (
      !efr_q[g][7] && TX_START_REQ[g] |=> TX_START_OK[g])
      else $error("clear-to-send blocked without auto-flow");
    a_irq_gate_off: assert property (
      MODE_SEP_CS && !irq_sel_f && !mcr_q[g][3] |=> !CHANNEL_IRQ_OE[g] && !CHANNEL_IRQ_OUT[g])
      else $error("interrupt driven with control bit3 clear");
    a_irq_sel_force: assert property (
      MODE_SEP_CS && irq_sel_f |=> CHANNEL_IRQ_OE[g])
      else $error("select pin high but interrupt not driven");
    a_irq_needs_cause: assert property (
      CHANNEL_IRQ_OUT[g] |-> $past(ier_q[g][3:0]) != 4'h0)
      else $error("interrupt with no source enabled");
    a_shared_mode_off: assert property (
      !MODE_SEP_CS |=> !CHANNEL_IRQ_OE[g])
      else $error("per-channel interrupt driven in shared mode");
    a_delta_on_change: assert property (
      cts_act[g] != cts_prev_q[g] |=> dcts_q[g])
      else $error("clear-to-send change not flagged");
  end

endmodule : ump_modem_irq

// file: tb/ump_modem_model.sv
`timescale 1ns/10ps
// ************************************************
// Modem side of each channel
// ************************************************
module ump_modem_model #(
  parameter int NCH = 4
)(
  input  wire logic           clk,
  input  wire logic [NCH-1:0] cts_ready,
  input  wire logic [NCH-1:0] dsr_ready,
  output logic      [NCH-1:0] cts_b,
  output logic      [NCH-1:0] dsr_b
);
  // Pins idle inactive until the modem says otherwise
  initial
  begin
    cts_b = '1;
    dsr_b = '1;
  end
  always @(posedge clk)
  begin
    cts_b <= ~cts_ready;
    dsr_b <= ~dsr_ready;
  end
endmodule : ump_modem_model

// file: tb/test_ump_modem_irq.sv
`timescale 1ns/10ps
module test_ump_modem_irq
  import ump_pkg::*;
;
  logic clk = 0, rst_b = 0, sep = 0, sel = 0;
  logic [3:0] mcr_wr = 0, efr_wr = 0, ier_wr = 0, msr_rd = 0, tx_req = 0;
  logic [3:0] cts_rdy = 0, dsr_rdy = 0, cts_b, dsr_b, tx_ok, dtr_b, irq_out, irq_oe;
  logic [7:0] dbus = 0, bus_o;
  logic bus_oe;
  ump_irq_src_t [3:0] src = '0;
  int failures = 0, samples_checked = 0;
  always #50 clk = ~clk;
  ump_modem_model u_modem (.clk(clk), .cts_ready(cts_rdy), .dsr_ready(dsr_rdy),
    .cts_b(cts_b), .dsr_b(dsr_b));
  ump_modem_irq dut_u (.CLK(clk), .RST_B(rst_b), .MODE_SEP_CS(sep),
    .IRQ_OUTPUT_SELECT(sel), .CTS_B(cts_b), .DSR_B(dsr_b), .MCR_WR(mcr_wr),
    .EFR_WR(efr_wr), .IER_WR(ier_wr), .MSR_RD(msr_rd), .HOST_DATA_BUS_I(dbus),
    .IRQ_SRC(src), .TX_START_REQ(tx_req), .TX_START_OK(tx_ok), .DTR_B(dtr_b),
    .CHANNEL_IRQ_OUT(irq_out), .CHANNEL_IRQ_OE(irq_oe), .HOST_DATA_BUS_O(bus_o),
    .HOST_DATA_BUS_OE(bus_oe));
  // ************************************************
  // Access tasks
  // ************************************************
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp(string name, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  // Kind 0 control, 1 feature, 2 enable, 3 status read
  task automatic acc(int k, int ch, logic [7:0] d);
    @(posedge clk);
    dbus <= d;
    case (k)
      0: mcr_wr[ch] <= 1'b1;
      1: efr_wr[ch] <= 1'b1;
      2: ier_wr[ch] <= 1'b1;
      default: msr_rd[ch] <= 1'b1;
    endcase
    @(posedge clk);
    {mcr_wr, efr_wr, ier_wr, msr_rd} <= '0;
    #1;
  endtask : acc
  task automatic tx(int ch, logic e);
    @(posedge clk);
    tx_req[ch] <= 1'b1;
    @(posedge clk);
    tx_req <= '0;
    #1;
    cmp("tx_ok", {7'h00, e}, {7'h00, tx_ok[ch]});
  endtask : tx
  task automatic cirq(logic [1:0] e);
    tick(2);
    cmp("irq oe,out", {6'h00, e}, {6'h00, irq_oe[2], irq_out[2]});
  endtask : cirq
  task automatic print_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // ************************************************
  // Tests
  // ************************************************
  initial
  begin
    tick(6);
    rst_b <= 1'b1;
    tick(1);
    cmp("dtr", 8'h0f, {4'h0, dtr_b});
    acc(0, 0, 8'h01);
    cmp("dtr", 8'h0e, {4'h0, dtr_b});
    acc(0, 0, 8'h00);
    cmp("dtr", 8'h0f, {4'h0, dtr_b});
    dsr_rdy[1] <= 1'b1;
    tick(8);
    acc(3, 1, 8'h00);
    cmp("status", 8'h22, bus_o);
    cmp("bus oe", 8'h01, {7'h00, bus_oe});
    acc(3, 1, 8'h00);
    cmp("status", 8'h20, bus_o);
    tx(1, 1'b1);
    acc(1, 1, 8'h80);
    tx(1, 1'b0);
    cts_rdy[1] <= 1'b1;
    tick(8);
    tx(1, 1'b1);
    acc(3, 1, 8'h00);
    cmp("status", 8'h31, bus_o);
    // Interrupts on channel 2
    sep <= 1'b1;
    src[2] <= ump_irq_src_t'(3'b001);
    acc(2, 2, 8'h01);
    cirq(2'b00);
    acc(0, 2, 8'h08);
    cirq(2'b11);
    for (int k = 0; k < 3; k++)
    begin
      src[2] <= ump_irq_src_t'(3'b001 << k);
      acc(2, 2, 8'h01 << k);
      cirq(2'b11);
      src[2] <= ump_irq_src_t'(3'b001 << ((k + 1) % 3));
      cirq(2'b10);
    end
    src[2] <= '0;
    dsr_rdy[2] <= 1'b1;
    acc(2, 2, 8'h08);
    tick(8);
    cirq(2'b11);
    sel <= 1'b1;
    acc(0, 2, 8'h00);
    tick(8);
    cirq(2'b11);
    sep <= 1'b0;
    cirq(2'b00);
    print_verdict();
  end
  // Whole run needs under a hundred cycles
  initial
  begin
    #500000;
    failures++;
    print_verdict();
  end
endmodule : test_ump_modem_irq
